// ---- hw/lcd_command_address_decoder.v ----
// command decoder, display ram addressing and pixel scan of an lcd driver
// assumes host pins are asynchronous to mclk_i and held stable around strobes
//
// Behaviour
// - command 01xxxxxx loads six-bit display start line, 0 to 63
// - scan 65 lines upward from start line; rewriting start scrolls vertically
// - command 1011xxxx loads host access page, pages 0 to 8
// - host page address never changes what the panel shows
// - column set in two bytes: 0001 high nibble, 0000 low nibble
// - each display data write or read advances column by one
// - column counter saturates at FFh instead of wrapping
// - page address never advances on its own
// - status read gives busy, segment direction, display off, resetting, zeros
// - segment bit reads 1 normal, 0 reversed (column 199-n on segment n)
// - display status bit reads 1 when display is off
// - resetting bit reads 1 while reset initialisation runs
// - data write stores byte at current page and column, then advances
// - data read drives byte latched by previous read, latches current page and column, then advances
// - first read after column set is a dummy; valid data from second
// - serial interface offers no read path
// - command 1010000x selects normal or reversed segment mapping
// - segment direction leaves column auto-increment counting upward
// - command 1010011x selects normal or inverse pixels, ram untouched
// - command 1010010x lights all pixels or returns to normal
// - all-pixels-on overrides inverse display
// - serial bytes arrive most significant bit first
// - reset clears column, page, start line, selects normal segment direction
`include "lcd_cmd_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module lcd_command_address_decoder (
  input wire mclk_i,
  input wire rstn_i,
  input wire serial_mode_i,
  input wire command_data_select_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire [7:0] data_i,
  output wire [7:0] data_o,
  output wire data_oe_n_o,
  input wire serial_cs_n_i,
  input wire serial_clk_i,
  input wire serial_data_i,
  output wire [6:0] com_line_o,
  output wire [7:0] seg_index_o,
  output wire pixel_o
);
  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n;
  reg [14:0] pin_s1_ff;
  reg [14:0] pin_s2_ff;
  wire [14:0] pin_raw;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  assign pin_raw = {serial_mode_i, command_data_select_i, rd_n_i, wr_n_i, data_i,
                    serial_cs_n_i, serial_clk_i, serial_data_i};

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= `RST_PINS;
      pin_s2_ff <= `RST_PINS;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  wire ser_mode_s = pin_s2_ff[14];
  wire cds_s = pin_s2_ff[13];
  wire rd_n_s = pin_s2_ff[12];
  wire wr_n_s = pin_s2_ff[11];
  wire [7:0] dat_s = pin_s2_ff[10:3];
  wire scs_n_s = pin_s2_ff[2];
  wire sclk_s = pin_s2_ff[1];
  wire sdat_s = pin_s2_ff[0];

  // ****************************************
  // host port capture
  // ****************************************
  reg rd_n_d_ff;
  reg wr_n_d_ff;
  reg sclk_d_ff;
  reg [6:0] shift_ff;
  reg [2:0] bit_cnt_ff;
  wire rd_fall;
  wire wr_fall;
  wire sclk_rise;
  wire ser_byte;
  reg push_valid;
  reg [`ENT_WIDTH-1:0] push_data;
  wire push_ready;
  wire pop_valid;
  wire pop_ready;
  wire [`ENT_WIDTH-1:0] pop_data;

  // parallel strobes are ignored in serial mode, so no read path exists there
  assign rd_fall = rd_n_d_ff & ~rd_n_s & ~ser_mode_s;
  assign wr_fall = wr_n_d_ff & ~wr_n_s & ~ser_mode_s;
  assign sclk_rise = ~sclk_d_ff & sclk_s & ~scs_n_s & ser_mode_s;
  assign ser_byte = sclk_rise & (bit_cnt_ff == 3'h7);

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_d_ff <= 1'b1;
      wr_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
      shift_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
    end else begin
      rd_n_d_ff <= rd_n_s;
      wr_n_d_ff <= wr_n_s;
      sclk_d_ff <= sclk_s;
      if (scs_n_s || !ser_mode_s) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        shift_ff <= {shift_ff[5:0], sdat_s};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  always @* begin
    push_valid = 1'b0;
    push_data = {`ENT_WIDTH{1'b0}};
    if (ser_byte) begin
      push_valid = 1'b1;
      push_data = {1'b0, cds_s, shift_ff, sdat_s};
    end else if (wr_fall) begin
      push_valid = 1'b1;
      push_data = {1'b0, cds_s, dat_s};
    end else if (rd_fall && cds_s) begin
      push_valid = 1'b1;
      push_data = {1'b1, 1'b1, 8'h00};
    end
  end

  // a byte that meets a full buffer is lost; busy warns the host beforehand
  lcd_byte_buffer #(
    .WIDTH(`ENT_WIDTH)
  ) u_buf (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  // ****************************************
  // control state and command decode
  // ****************************************
  localparam [8:0] RST_CYC = `RESET_CYCLES;
  reg [8:0] rst_cnt_ff;
  reg resetting_ff;
  reg [5:0] start_line_ff;
  reg [3:0] page_ff;
  reg [7:0] col_ff;
  reg seg_rev_ff;
  reg inverse_ff;
  reg all_on_ff;
  reg disp_on_ff;
  reg skip_next_ff;
  reg [7:0] rd_latch_ff;
  reg [7:0] data_out_ff;
  reg [7:0] mem [0:1799];
  wire [7:0] cmd = pop_data[7:0];
  wire pop;
  wire is_read;
  wire is_write;
  wire is_cmd;
  wire col_ok;
  wire [10:0] host_idx;
  wire [7:0] col_inc;
  wire busy;
  wire [7:0] status;

  assign pop_ready = ~resetting_ff;
  assign pop = pop_valid & pop_ready;
  assign is_read = pop & pop_data[`ENT_READ];
  assign is_write = pop & ~pop_data[`ENT_READ] & pop_data[`ENT_CDS];
  assign is_cmd = pop & ~pop_data[`ENT_READ] & ~pop_data[`ENT_CDS];
  assign col_ok = (col_ff < `NUM_COLS) & (page_ff <= `LAST_PAGE);
  assign host_idx = ({7'h00, page_ff} * 11'h0C8) + {3'h0, col_ff};
  // upward count regardless of segment direction, page untouched
  assign col_inc = (col_ff == `COL_MAX) ? col_ff : col_ff + 8'h01;

  // pending work in the buffer also reads as busy
  assign busy = resetting_ff | pop_valid;
  assign status = {busy, ~seg_rev_ff, ~disp_on_ff, resetting_ff, 4'h0};

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_ff <= 9'h000;
      resetting_ff <= 1'b1;
      start_line_ff <= `RST_START_LINE;
      page_ff <= `RST_PAGE;
      col_ff <= `RST_COL;
      seg_rev_ff <= 1'b0;
      inverse_ff <= 1'b0;
      all_on_ff <= 1'b0;
      disp_on_ff <= 1'b0;
      skip_next_ff <= 1'b0;
      rd_latch_ff <= 8'h00;
      data_out_ff <= 8'h00;
    end else begin
      if (resetting_ff) begin
        rst_cnt_ff <= rst_cnt_ff + 9'h001;
        if (rst_cnt_ff == RST_CYC - 9'h001) begin
          resetting_ff <= 1'b0;
        end
      end
      if (rd_fall && !cds_s) begin
        data_out_ff <= status;
      end else if (is_read) begin
        // host gets the older latch, the latch fetches the current address
        data_out_ff <= rd_latch_ff;
      end
      if (is_read) begin
        rd_latch_ff <= col_ok ? mem[host_idx] : 8'h00;
        col_ff <= col_inc;
      end
      if (is_write) begin
        col_ff <= col_inc;
      end
      if (is_cmd) begin
        if (skip_next_ff) begin
          // argument byte of a two-byte command outside this block
          skip_next_ff <= 1'b0;
        end else if (cmd[7:6] == `CMD_START_LINE) begin
          start_line_ff <= cmd[5:0];
        end else if (cmd[7:4] == `CMD_PAGE) begin
          if (cmd[3:0] <= `LAST_PAGE) begin
            page_ff <= cmd[3:0];
          end
        end else if (cmd[7:4] == `CMD_COL_HI) begin
          col_ff[7:4] <= cmd[3:0];
        end else if (cmd[7:4] == `CMD_COL_LO) begin
          col_ff[3:0] <= cmd[3:0];
        end else if (cmd[7:1] == `CMD_SEG_DIR) begin
          seg_rev_ff <= cmd[0];
        end else if (cmd[7:1] == `CMD_INVERSE) begin
          inverse_ff <= cmd[0];
        end else if (cmd[7:1] == `CMD_ALL_ON) begin
          all_on_ff <= cmd[0];
        end else if (cmd[7:1] == `CMD_DISP_ON) begin
          disp_on_ff <= cmd[0];
        end else if ((cmd == `CMD_VOLUME_MODE) || (cmd[7:1] == `CMD_STATIC_IND)) begin
          skip_next_ff <= 1'b1;
        end
      end
    end
  end

  // ram storage holds no reset; its contents survive display mode changes
  always @(posedge mclk_i) begin
    if (is_write && col_ok) begin
      mem[host_idx] <= cmd;
    end
  end

  assign data_o = data_out_ff;
  // drives while the synchronised read strobe is low in parallel mode
  assign data_oe_n_o = rd_n_s | ser_mode_s;

  // ****************************************
  // display scan
  // ****************************************
  reg [6:0] line_cnt_ff;
  reg [7:0] seg_cnt_ff;
  reg [6:0] com_ff;
  reg [7:0] seg_ff;
  reg pixel_ff;
  wire [6:0] line_sum;
  wire [6:0] ram_line;
  wire [7:0] scan_col;
  wire [10:0] scan_idx;
  wire [7:0] scan_byte;
  wire ram_bit;

  // only the start line picks the shown row; host page is not involved
  assign line_sum = {1'b0, start_line_ff} + line_cnt_ff;
  assign ram_line = (line_sum >= `NUM_LINES) ? line_sum - `NUM_LINES : line_sum;
  assign scan_col = seg_rev_ff ? `LAST_SEG - seg_cnt_ff : seg_cnt_ff;
  assign scan_idx = ({7'h00, ram_line[6:3]} * 11'h0C8) + {3'h0, scan_col};
  assign scan_byte = mem[scan_idx];
  assign ram_bit = scan_byte[ram_line[2:0]];

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_ff <= 7'h00;
      seg_cnt_ff <= 8'h00;
      com_ff <= 7'h00;
      seg_ff <= 8'h00;
      pixel_ff <= 1'b0;
    end else begin
      if (seg_cnt_ff == `LAST_SEG) begin
        seg_cnt_ff <= 8'h00;
        line_cnt_ff <= (line_cnt_ff == `NUM_LINES - 7'h01) ? 7'h00 : line_cnt_ff + 7'h01;
      end else begin
        seg_cnt_ff <= seg_cnt_ff + 8'h01;
      end
      com_ff <= line_cnt_ff;
      seg_ff <= seg_cnt_ff;
      if (!disp_on_ff) begin
        pixel_ff <= 1'b0;
      end else if (all_on_ff) begin
        pixel_ff <= 1'b1;
      end else begin
        pixel_ff <= ram_bit ^ inverse_ff;
      end
    end
  end

  assign com_line_o = com_ff;
  assign seg_index_o = seg_ff;
  assign pixel_o = pixel_ff;
endmodule
`default_nettype wire

// ---- hw/lcd_cmd_defines.vh ----
// command codes, field positions, reset values and timing counts of the
// lcd command and address decoder; assumes a 250 MHz core clock
`ifndef LCD_CMD_DEFINES_VH
`define LCD_CMD_DEFINES_VH

// timing
`define MCLK_MHZ 250
`define RESET_TIME_NS 1000
// 1000 ns at 250 MHz, sized to the 9-bit reset counter
`define RESET_CYCLES 9'h0FA

// geometry
`define NUM_LINES 7'h41
`define NUM_COLS 8'hC8
`define LAST_SEG 8'hC7
`define LAST_PAGE 4'h8
`define COL_MAX 8'hFF

// command patterns
`define CMD_START_LINE 2'h1
`define CMD_PAGE 4'hB
`define CMD_COL_HI 4'h1
`define CMD_COL_LO 4'h0
`define CMD_SEG_DIR 7'h50
`define CMD_ALL_ON 7'h52
`define CMD_INVERSE 7'h53
`define CMD_DISP_ON 7'h57
`define CMD_STATIC_IND 7'h56
`define CMD_VOLUME_MODE 8'h81

// status byte bit positions
`define ST_BUSY 7
`define ST_SEG_NORMAL 6
`define ST_DISP_OFF 5
`define ST_RESETTING 4

// reset values
`define RST_START_LINE 6'h00
`define RST_PAGE 4'h0
`define RST_COL 8'h00
// idle pins: parallel mode, strobes and chip select high, serial clock high
`define RST_PINS 15'h1806

// buffer entry layout
`define ENT_READ 9
`define ENT_CDS 8
`define ENT_WIDTH 10

`endif

// ---- hw/lcd_byte_buffer.v ----
// two-entry valid/ready buffer between host port capture and the decoder
// assumes one clock and an already synchronised active-low reset
`timescale 1ns/100ps
`default_nettype none
module lcd_byte_buffer #(
  parameter WIDTH = 10
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] data0_ff;
  reg [WIDTH-1:0] data1_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  assign in_ready_o = (count_ff != 2'h2);
  assign out_valid_o = (count_ff != 2'h0);
  assign out_data_o = data0_ff;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data0_ff <= {WIDTH{1'b0}};
      data1_ff <= {WIDTH{1'b0}};
      count_ff <= 2'h0;
    end else begin
      if (pop) begin
        // head moves up; a word pushed in the same cycle takes the freed slot
        if (count_ff == 2'h2) begin
          data0_ff <= data1_ff;
        end else if (push) begin
          data0_ff <= in_data_i;
        end
        if (push && (count_ff == 2'h2)) begin
          data1_ff <= in_data_i;
        end
      end else if (push) begin
        if (count_ff == 2'h0) begin
          data0_ff <= in_data_i;
        end else begin
          data1_ff <= in_data_i;
        end
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ---- testbench/lcd_cad_checker.sv ----
// checker of lcd decoder port timing and scan order
// assumes bind to the decoder top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module lcd_cad_checker (
  input wire mclk_i,
  input wire rstn_i,
  input wire serial_mode_i,
  input wire command_data_select_i,
  input wire rd_n_i,
  input wire [7:0] data_o,
  input wire data_oe_n_o,
  input wire [6:0] com_line_o,
  input wire [7:0] seg_index_o
);
  // ****
  // checks
  // ****
  logic [2:0] up_ff;
  // scan starts late after reset, so step checks wait a few edges
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_oe_on_read: assert property ((!rd_n_i && !serial_mode_i)[*4] |-> !data_oe_n_o)
    else $error("data bus idle during read");
  a_serial_no_read: assert property (serial_mode_i[*4] |-> data_oe_n_o)
    else $error("data bus driven in serial mode");
  a_status_low: assert property (
    (!rd_n_i && !command_data_select_i)[*6] |-> data_o[3:0] == 4'h0)
    else $error("status low bits not zero");
  a_data_hold: assert property ($changed(data_o) |-> !$past(rd_n_i) || !$past(rd_n_i, 2))
    else $error("read data moved without read");
  a_seg_range: assert property (seg_index_o <= 8'hC7)
    else $error("segment index out of range");
  a_seg_step: assert property (
    up_ff == 3'h7 && $past(seg_index_o) != 8'hC7 |-> seg_index_o == $past(seg_index_o) + 8'h01)
    else $error("segment scan skipped");
  a_com_wrap: assert property ($past(seg_index_o) == 8'hC7 && up_ff == 3'h7 |->
    com_line_o == ($past(com_line_o) == 7'h40 ? 7'h00 : $past(com_line_o) + 7'h01))
    else $error("line scan wrong after row end");
  a_com_step: assert property ($changed(com_line_o) |-> $past(seg_index_o) == 8'hC7)
    else $error("line moved mid row");
  c_status: cover property ((!rd_n_i && !command_data_select_i)[*6]);
  c_data_read: cover property ((!rd_n_i && command_data_select_i && !serial_mode_i)[*6]);
  c_frame: cover property ($changed(com_line_o) && com_line_o == 7'h00);
endmodule
bind lcd_command_address_decoder lcd_cad_checker lcd_cad_checker_i (.mclk_i, .rstn_i,
  .serial_mode_i, .command_data_select_i, .rd_n_i, .data_o, .data_oe_n_o, .com_line_o,
  .seg_index_o);
`default_nettype wire

// ---- testbench/lcd_host_model.sv ----
// host side model: parallel strobes and serial shifting toward the decoder
// assumes pins change on falling edges of the decoder clock
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i,
  output logic serial_mode_o,
  output logic cds_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] data_o,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdata_o
);
  // ****
  // bus tasks
  // ****
  logic [7:0] drv = 8'hA5;
  logic oe_seen = 1'b1;
  // wire level: device while it drives, else the host byte, inverted once a write ends
  assign data_o = dev_oe_n_i ? drv : dev_data_i;
  initial {serial_mode_o, cds_o, rd_n_o, wr_n_o, cs_n_o, sclk_o, sdata_o} = 7'h1E;
  task automatic wr(input logic c, input logic [7:0] b);
    @(negedge mclk_i);
    cds_o = c;
    drv = b;
    wr_n_o = 1'b0;
    repeat (7) @(negedge mclk_i);
    wr_n_o = 1'b1;
    drv = ~b;
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic rd(input logic c, output logic [7:0] b);
    @(negedge mclk_i);
    cds_o = c;
    rd_n_o = 1'b0;
    repeat (7) @(negedge mclk_i);
    b = data_o;
    oe_seen = dev_oe_n_i;
    rd_n_o = 1'b1;
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic ser(input logic c, input logic [7:0] b);
    integer i;
    @(negedge mclk_i);
    cds_o = c;
    cs_n_o = 1'b0;
    for (i = 7; i >= 0; i--) begin
      sdata_o = b[i];
      sclk_o = 1'b0;
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b1;
      repeat (5) @(negedge mclk_i);
    end
    cs_n_o = 1'b1;
    sdata_o = ~b[0];
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic sm(input logic s);
    @(negedge mclk_i);
    serial_mode_o = s;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ---- testbench/lcd_command_address_decoder_tb_top.sv ----
// bench: reference model of the decoder compared at status, reads and pixels
// assumes the host model drives all pins on falling edges
`timescale 1ns/100ps
`default_nettype none
module lcd_command_address_decoder_tb_top;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic smode, cds, rd_n, wr_n, oe_n, cs_n, sclk, sdat, pix;
  logic [7:0] din, dout, seg, v, latch = 8'h00, col = 8'h00;
  logic [6:0] com;
  logic [7:0] ram [0:1799];
  logic [3:0] page = 4'h0;
  logic [5:0] start = 6'h00;
  logic rev = 1'b0, inv = 1'b0, allon = 1'b0, off = 1'b1, ser = 1'b0;
  integer errors = 0, check_count = 0, seed = 32'h93fe, i;
  logic [7:0] ops [$] = '{8'hAF, 8'hA1, 8'hA0, 8'hA7, 8'hA6, 8'hA5, 8'hA4, 8'hAE, 8'hAF};
  always #2 mclk_i = ~mclk_i;
  lcd_command_address_decoder lcd_command_address_decoder_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .serial_mode_i(smode), .command_data_select_i(cds), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(din), .data_o(dout), .data_oe_n_o(oe_n), .serial_cs_n_i(cs_n),
    .serial_clk_i(sclk), .serial_data_i(sdat), .com_line_o(com), .seg_index_o(seg),
    .pixel_o(pix));
  lcd_host_model lcd_host_model_i (.mclk_i(mclk_i), .dev_data_i(dout), .dev_oe_n_i(oe_n),
    .serial_mode_o(smode), .cds_o(cds), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din),
    .cs_n_o(cs_n), .sclk_o(sclk), .sdata_o(sdat));
  // ****
  // model and checks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    if (b[7:6] == 2'h1) start = b[5:0];
    if (b[7:4] == 4'hB && b[3:0] <= 4'h8) page = b[3:0];
    if (b[7:4] == 4'h1) col[7:4] = b[3:0];
    if (b[7:4] == 4'h0) col[3:0] = b[3:0];
    if (b[7:1] == 7'h50) rev = b[0];
    if (b[7:1] == 7'h53) inv = b[0];
    if (b[7:1] == 7'h52) allon = b[0];
    if (b[7:1] == 7'h57) off = !b[0];
    if (ser) lcd_host_model_i.ser(1'b0, b);
    else lcd_host_model_i.wr(1'b0, b);
  endtask
  task automatic dwr(input logic [7:0] b);
    if (col < 8'hC8) ram[page * 200 + col] = b;
    if (col != 8'hFF) col++;
    if (ser) lcd_host_model_i.ser(1'b1, b);
    else lcd_host_model_i.wr(1'b1, b);
  endtask
  task automatic drd();
    lcd_host_model_i.rd(1'b1, v);
    chk("read data", latch, v);
    chk("read drive", 8'h00, {7'h00, lcd_host_model_i.oe_seen});
    latch = (col < 8'hC8) ? ram[page * 200 + col] : 8'h00;
    if (col != 8'hFF) col++;
  endtask
  task automatic stat();
    lcd_host_model_i.rd(1'b0, v);
    chk("status", {1'b0, !rev, off, 5'h00}, v);
  endtask
  task automatic scan();
    integer l;
    logic [7:0] d;
    logic e;
    repeat (13000) begin
      @(negedge mclk_i);
      l = (start + com) % 65;
      d = ram[l / 8 * 200 + (rev ? 8'hC7 - seg : seg)];
      e = off ? 1'b0 : allon ? 1'b1 : d[l % 8] ^ inv;
      if (!$isunknown(e)) chk("pixel", {7'h00, e}, {7'h00, pix});
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    lcd_host_model_i.rd(1'b0, v);
    chk("reset status", 8'hF0, v);
    cmd(8'h05);
    cmd(8'h11);
    // third byte while reset initialisation runs finds the buffer full and is lost
    lcd_host_model_i.wr(1'b0, 8'h13);
    repeat (300) @(negedge mclk_i);
    stat();
    foreach (ops[i]) begin
      cmd(ops[i]);
      stat();
    end
    dwr(8'h3C);
    cmd(8'h00);
    for (i = 0; i < 8; i++) dwr(8'($random(seed)));
    cmd(8'hB8);
    cmd(8'h0C);
    for (i = 0; i < 8; i++) dwr(8'($random(seed)));
    cmd(8'hB9);
    cmd(8'h0E);
    cmd(8'h1F);
    for (i = 0; i < 4; i++) dwr(8'h55);
    cmd(8'h11);
    cmd(8'hA1);
    for (i = 0; i < 4; i++) drd();
    cmd(8'hA0);
    cmd(8'hB0);
    cmd(8'h00);
    cmd(8'h10);
    for (i = 0; i < 4; i++) drd();
    cmd(8'h05);
    cmd(8'h11);
    drd();
    drd();
    lcd_host_model_i.sm(1'b1);
    ser = 1'b1;
    cmd(8'h08);
    dwr(8'($random(seed)));
    lcd_host_model_i.rd(1'b1, v);
    chk("serial drive", 8'h01, {7'h00, lcd_host_model_i.oe_seen});
    dwr(8'($random(seed)));
    lcd_host_model_i.sm(1'b0);
    ser = 1'b0;
    cmd(8'h08);
    for (i = 0; i < 3; i++) drd();
    cmd(8'h7C);
    cmd(8'hB3);
    scan();
    cmd(8'hA1);
    cmd(8'hA7);
    cmd(8'h41);
    scan();
    cmd(8'hA5);
    scan();
    summarize();
  end
  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
